// file: rtl/irq_entry.sv
// Interrupt recognition, stacking, priority resolution and mode register.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module irq_entry #(
  parameter logic [15:0] VEC_TOP = 16'hFFFE
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [15:0]           awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [15:0]           araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire logic [1:0]            mode_strap_pin,
  input  wire logic                  nonmaskable_request_pin_n,
  input  wire logic                  clock_monitor_fail,
  input  wire logic                  watchdog_timer_fail,
  input  wire logic                  illegal_opcode,
  input  wire logic [14:0]           mask_req,
  input  wire logic                  instr_done,
  input  wire logic                  software_trap_fetch,
  input  wire logic                  return_from_trap_start,
  input  wire logic                  ccr_wr,
  input  wire logic [7:0]            ccr_wdata,
  input  wire irq_pkg::cpu_ctx_s     cpu_ctx,
  input  wire logic                  stk_rvalid,
  input  wire logic [7:0]            stk_rdata,
  input  wire logic [15:0]           mem_addr,
  input  wire logic                  internal_read,
  output logic                       busy_q,
  output logic                       stk_push_q,
  output logic                       stk_pop_q,
  output logic [7:0]                 stk_wdata_q,
  output logic                       vec_load_q,
  output logic [15:0]                vec_addr_q,
  output logic                       restore_valid_q,
  output irq_pkg::cpu_ctx_s          restore_q,
  output logic                       i_mask_q,
  output logic                       x_mask_q,
  output logic                       boot_rom_sel_q,
  output logic                       irv_drive_q,
  output logic                       mode_a_select,
  output logic                       special_variant_flag
);
  if (VEC_TOP[0] != 1'b0) begin : g_chk
    $error("VEC_TOP must be even");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ctx_byte(irq_pkg::cpu_ctx_s c, logic [3:0] k);
    case (k)
      4'h0:    ctx_byte = c.pc[7:0];
      4'h1:    ctx_byte = c.pc[15:8];
      4'h2:    ctx_byte = c.iy[7:0];
      4'h3:    ctx_byte = c.iy[15:8];
      4'h4:    ctx_byte = c.ix[7:0];
      4'h5:    ctx_byte = c.ix[15:8];
      4'h6:    ctx_byte = c.acc_a;
      4'h7:    ctx_byte = c.acc_b;
      default: ctx_byte = c.condition_code_byte;
    endcase
  endfunction

  function automatic irq_pkg::cpu_ctx_s ctx_put(irq_pkg::cpu_ctx_s c, logic [3:0] k,
                                                logic [7:0] b);
    ctx_put = c;
    case (k)
      4'h0:    ctx_put.pc[7:0]   = b;
      4'h1:    ctx_put.pc[15:8]  = b;
      4'h2:    ctx_put.iy[7:0]   = b;
      4'h3:    ctx_put.iy[15:8]  = b;
      4'h4:    ctx_put.ix[7:0]   = b;
      4'h5:    ctx_put.ix[15:8]  = b;
      4'h6:    ctx_put.acc_a     = b;
      4'h7:    ctx_put.acc_b     = b;
      default: ctx_put.condition_code_byte       = b;
    endcase
  endfunction

  // Code 0101 is reserved and falls back to the external request.
  function automatic logic [3:0] promote(logic [3:0] code);
    case (code)
      4'h0:    promote = irq_pkg::SRC_TOF;
      4'h1:    promote = irq_pkg::SRC_PAOV;
      4'h2:    promote = irq_pkg::SRC_PAIE;
      4'h3:    promote = irq_pkg::SRC_SPI;
      4'h4:    promote = irq_pkg::SRC_SCI;
      4'h5:    promote = irq_pkg::SRC_IRQ;
      4'h6:    promote = irq_pkg::SRC_IRQ;
      4'h7:    promote = irq_pkg::SRC_RTII;
      4'h8:    promote = irq_pkg::SRC_IC1;
      4'h9:    promote = irq_pkg::SRC_IC1;
      4'hA:    promote = irq_pkg::SRC_IC2;
      default: promote = 4'(code - 4'hB) + irq_pkg::SRC_OC1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] xs_q;
  logic [1:0] st1_q, st2_q, st3_q;
  logic       nonmaskable_request_pin_act_q;

  always_ff @(posedge aclk) begin
    xs_q  <= {xs_q[1:0], ~nonmaskable_request_pin_n};
    st1_q <= mode_strap_pin;
    st2_q <= st1_q;
    st3_q <= st2_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nonmaskable_request_pin_act_q <= 1'b0;
    end else if (xs_q[1] == xs_q[2]) begin
      nonmaskable_request_pin_act_q <= xs_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  irq_pkg::seq_e state_q;
  logic [3:0]    cnt_q;
  logic          swi_lock_q;
  logic          i_old_q;
  logic          x_old_q;
  logic [4:0]    slot_q;
  logic [7:0]    prio_q;
  logic          mask_pend;
  logic          nm_pend;
  logic          push_last;
  logic [4:0]    slot_d;
  logic [3:0]    prom;

  assign mask_pend = |mask_req && !i_mask_q;
  assign nm_pend   = clock_monitor_fail || watchdog_timer_fail || illegal_opcode
                     || (nonmaskable_request_pin_act_q && !x_mask_q);
  assign push_last = state_q == irq_pkg::ST_PUSH && cnt_q == irq_pkg::LAST_BYTE;
  assign prom      = promote(prio_q[3:0]);

  // Sampling happens here, after stacking, so a late higher source wins.
  always_comb begin
    slot_d = {1'b0, irq_pkg::SRC_IRQ};
    if (swi_lock_q) begin
      slot_d = irq_pkg::SLOT_SWI;
    end else if (clock_monitor_fail) begin
      slot_d = irq_pkg::SLOT_CMF;
    end else if (watchdog_timer_fail) begin
      slot_d = irq_pkg::SLOT_COP;
    end else if (illegal_opcode) begin
      slot_d = irq_pkg::SLOT_ILL;
    end else if (nonmaskable_request_pin_act_q && !x_old_q) begin
      slot_d = irq_pkg::SLOT_XRQ;
    end else if (!i_old_q && mask_req[prom]) begin
      slot_d = {1'b0, prom};
    end else if (!i_old_q) begin
      for (int n = irq_pkg::NUM_MASK - 1; n >= 0; n--) begin
        if (mask_req[n]) begin
          slot_d = 5'(n);
        end
      end
    end
  end

  // A long multiply or divide simply delays the boundary pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q         <= irq_pkg::ST_IDLE;
      cnt_q           <= 4'h0;
      swi_lock_q      <= 1'b0;
      i_old_q         <= 1'b1;
      x_old_q         <= 1'b1;
      slot_q          <= 5'h00;
      stk_push_q      <= 1'b0;
      stk_pop_q       <= 1'b0;
      stk_wdata_q     <= 8'h00;
      vec_load_q      <= 1'b0;
      vec_addr_q      <= 16'h0000;
      restore_valid_q <= 1'b0;
      restore_q       <= '0;
      busy_q          <= 1'b0;
    end else begin
      stk_push_q      <= 1'b0;
      stk_pop_q       <= 1'b0;
      vec_load_q      <= 1'b0;
      restore_valid_q <= 1'b0;
      unique case (state_q)
        irq_pkg::ST_IDLE: begin
          cnt_q <= 4'h0;
          busy_q <= software_trap_fetch || return_from_trap_start || (instr_done && (mask_pend || nm_pend));
          if (software_trap_fetch) begin
            swi_lock_q <= 1'b1;
            state_q    <= irq_pkg::ST_PUSH;
          end else if (return_from_trap_start) begin
            state_q <= irq_pkg::ST_PULL;
          end else if (instr_done && (mask_pend || nm_pend)) begin
            state_q <= irq_pkg::ST_PUSH;
          end
        end
        irq_pkg::ST_PUSH: begin
          stk_push_q  <= 1'b1;
          stk_wdata_q <= ctx_byte(cpu_ctx, cnt_q);
          if (cnt_q == irq_pkg::LAST_BYTE) begin
            stk_wdata_q[irq_pkg::CCR_X_BIT] <= x_mask_q;
            stk_wdata_q[irq_pkg::CCR_I_BIT] <= i_mask_q;
            i_old_q <= i_mask_q;
            x_old_q <= x_mask_q;
            state_q <= irq_pkg::ST_RESOLVE;
          end
          cnt_q <= cnt_q + 4'h1;
        end
        irq_pkg::ST_RESOLVE: begin
          slot_q     <= slot_d;
          vec_load_q <= 1'b1;
          vec_addr_q <= VEC_TOP - {10'h000, slot_d, 1'b0};
          swi_lock_q <= 1'b0;
          busy_q     <= 1'b0;
          state_q    <= irq_pkg::ST_IDLE;
        end
        irq_pkg::ST_PULL: begin
          stk_pop_q <= 1'b1;
          state_q   <= irq_pkg::ST_PWAIT;
        end
        irq_pkg::ST_PWAIT: begin
          if (stk_rvalid) begin
            restore_q <= ctx_put(restore_q, irq_pkg::LAST_BYTE - cnt_q, stk_rdata);
            cnt_q     <= cnt_q + 4'h1;
            if (cnt_q == irq_pkg::LAST_BYTE) begin
              restore_valid_q <= 1'b1;
              busy_q          <= 1'b0;
              state_q         <= irq_pkg::ST_IDLE;
            end else begin
              state_q <= irq_pkg::ST_PULL;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mask bits: hardware sets win over software clears
  // ---------------------------------------------------------------
  logic       ccr_load;
  logic [7:0] ccr_val;

  assign ccr_load = ccr_wr || (state_q == irq_pkg::ST_PWAIT && stk_rvalid && cnt_q == 4'h0);
  assign ccr_val  = ccr_wr ? ccr_wdata : stk_rdata;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_mask_q <= 1'b1;
      x_mask_q <= 1'b1;
    end else begin
      if (push_last) begin
        i_mask_q <= 1'b1;
      end else if (ccr_load) begin
        i_mask_q <= ccr_val[irq_pkg::CCR_I_BIT];
      end
      if (push_last && nonmaskable_request_pin_act_q && !x_mask_q) begin
        x_mask_q <= 1'b1;
      end else if (ccr_load && !ccr_val[irq_pkg::CCR_X_BIT]) begin
        x_mask_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_full_q;
  logic        w_full_q;
  logic [15:0] aw_addr_q;
  logic [7:0]  w_byte_q;
  logic        w_lane_q;
  logic        wr_fire;
  logic        prio_we;

  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign prio_we = wr_fire && w_lane_q && aw_addr_q == irq_pkg::PRIO_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= irq_pkg::RESP_OK;
    end else begin
      awready <= !aw_full_q && !(awvalid && awready);
      wready  <= !w_full_q && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[15:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid    <= 1'b1;
        bresp     <= aw_addr_q == irq_pkg::PRIO_OFS ? irq_pkg::RESP_OK : irq_pkg::RESP_ERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= irq_pkg::RESP_OK;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= irq_pkg::RESP_OK;
        unique case ({araddr[15:2], 2'b00})
          irq_pkg::PRIO_OFS: rdata <= {24'h00_0000, prio_q};
          irq_pkg::STAT_OFS: rdata <= {23'h00_0000, swi_lock_q, busy_q, x_mask_q,
                                       i_mask_q, slot_q};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= irq_pkg::RESP_ERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Priority and mode control register
  // ---------------------------------------------------------------
  // Straps are taken while reset is held; strap 1x is special, x1 is mode A.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_q <= {st3_q[1] && !st3_q[0], st3_q[1], st3_q[0], 1'b0, irq_pkg::PSEL_RST};
    end else if (prio_we) begin
      if (prio_q[irq_pkg::SPECIAL_VARIANT_FLAG_BIT]) begin
        prio_q[irq_pkg::BOOT_BIT] <= w_byte_q[irq_pkg::BOOT_BIT];
        prio_q[irq_pkg::MDA_BIT]  <= w_byte_q[irq_pkg::MDA_BIT];
        prio_q[irq_pkg::IRV_BIT]  <= w_byte_q[irq_pkg::IRV_BIT] && w_byte_q[irq_pkg::SPECIAL_VARIANT_FLAG_BIT];
        if (!w_byte_q[irq_pkg::SPECIAL_VARIANT_FLAG_BIT]) begin
          prio_q[irq_pkg::SPECIAL_VARIANT_FLAG_BIT] <= 1'b0;
        end
      end
      if (i_mask_q) begin
        prio_q[3:0] <= w_byte_q[3:0];
      end
    end
  end

  assign mode_a_select        = prio_q[irq_pkg::MDA_BIT];
  assign special_variant_flag = prio_q[irq_pkg::SPECIAL_VARIANT_FLAG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_rom_sel_q <= 1'b0;
      irv_drive_q    <= 1'b0;
    end else begin
      boot_rom_sel_q <= prio_q[irq_pkg::BOOT_BIT] && mem_addr >= irq_pkg::ROM_LO
                        && mem_addr <= irq_pkg::ROM_HI;
      irv_drive_q    <= prio_q[irq_pkg::IRV_BIT] && internal_read;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Counting the pulses keeps the property short; a nine-fold repetition unrolls badly.
  logic [3:0] push_len_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_len_q <= 4'h0;
    end else if (stk_push_q) begin
      push_len_q <= push_len_q + 4'h1;
    end else begin
      push_len_q <= 4'h0;
    end
  end

  sequence push_run;
    stk_push_q ##9 (!stk_push_q && push_len_q == 4'h9);
  endsequence

  sequence resolve_done;
    vec_load_q && vec_addr_q == VEC_TOP - {10'h000, slot_q, 1'b0};
  endsequence

  boundary_take_a: assert property (state_q == irq_pkg::ST_IDLE && instr_done && nm_pend
    && !software_trap_fetch && !return_from_trap_start |=> state_q == irq_pkg::ST_PUSH)
    else $error("pending request not taken at boundary");
  no_abort_a: assert property (state_q == irq_pkg::ST_IDLE && !instr_done
    && !software_trap_fetch && !return_from_trap_start |=> state_q == irq_pkg::ST_IDLE)
    else $error("entry started without a boundary");
  push_count_a: assert property ($rose(state_q == irq_pkg::ST_PUSH) |=> push_run)
    else $error("stacking is not nine bytes");
  push_first_a: assert property ($rose(state_q == irq_pkg::ST_PUSH)
    |=> stk_wdata_q == $past(cpu_ctx.pc[7:0]))
    else $error("first stacked byte is not PC low");
  i_set_a: assert property (push_last |=> i_mask_q ##1 resolve_done)
    else $error("I not set or vector missing after stacking");
  x_set_a: assert property (push_last && nonmaskable_request_pin_act_q && !x_mask_q |=> x_mask_q)
    else $error("X not set on pin request");
  x_no_set_a: assert property ($rose(x_mask_q) |-> $past(push_last))
    else $error("X set other than by entry");
  swi_first_a: assert property (state_q == irq_pkg::ST_RESOLVE && swi_lock_q
    |=> vec_addr_q == VEC_TOP - {10'h000, irq_pkg::SLOT_SWI, 1'b0})
    else $error("trap vector lost to another source");
  psel_lock_a: assert property (prio_we && !i_mask_q |=> $stable(prio_q[3:0]))
    else $error("promote field written with I clear");
  upper_lock_a: assert property (!special_variant_flag |=> $stable(prio_q[7:4]))
    else $error("upper mode bits changed outside special");
  irv_off_a: assert property (!special_variant_flag |-> !prio_q[irq_pkg::IRV_BIT])
    else $error("read visibility on outside special");
  pc_last_a: assert property ($rose(restore_valid_q)
    |-> restore_q.pc[7:0] == $past(stk_rdata))
    else $error("program counter not pulled last");
endmodule
`default_nettype wire

// file: rtl/irq_pkg.sv
// Constants, types and register map for the interrupt entry block.
`default_nettype none
package irq_pkg;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] PRIO_OFS  = 16'h103C;
  localparam logic [15:0] STAT_OFS  = 16'h1040;
  localparam int          BOOT_BIT  = 7;
  localparam int          SPECIAL_VARIANT_FLAG_BIT  = 6;
  localparam int          MDA_BIT   = 5;
  localparam int          IRV_BIT   = 4;
  localparam logic [3:0]  PSEL_RST  = 4'h6;
  localparam int          CCR_X_BIT = 6;
  localparam int          CCR_I_BIT = 4;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // ---------------------------------------------------------------
  // Boot ROM window and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] ROM_LO       = 16'hBF40;
  localparam logic [15:0] ROM_HI       = 16'hBFFF;
  localparam int          ROM_BYTES    = 192;
  localparam int          MUL_CYC      = 10;
  localparam int          DIV_CYC      = 41;
  localparam logic [3:0]  LAST_BYTE    = 4'h8;
  // ---------------------------------------------------------------
  // Maskable sources, in fixed priority order, and vector slots
  // ---------------------------------------------------------------
  localparam int          NUM_MASK = 15;
  localparam logic [3:0]  SRC_IRQ  = 4'h0;
  localparam logic [3:0]  SRC_RTII = 4'h1;
  localparam logic [3:0]  SRC_IC1  = 4'h2;
  localparam logic [3:0]  SRC_IC2  = 4'h3;
  localparam logic [3:0]  SRC_OC1  = 4'h5;
  localparam logic [3:0]  SRC_TOF  = 4'hA;
  localparam logic [3:0]  SRC_PAOV = 4'hB;
  localparam logic [3:0]  SRC_PAIE = 4'hC;
  localparam logic [3:0]  SRC_SPI  = 4'hD;
  localparam logic [3:0]  SRC_SCI  = 4'hE;
  localparam logic [4:0]  SLOT_SWI = 5'h0F;
  localparam logic [4:0]  SLOT_ILL = 5'h10;
  localparam logic [4:0]  SLOT_COP = 5'h11;
  localparam logic [4:0]  SLOT_CMF = 5'h12;
  localparam logic [4:0]  SLOT_XRQ = 5'h13;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] iy;
    logic [15:0] ix;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [7:0]  condition_code_byte;
  } cpu_ctx_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_RESOLVE, ST_PULL, ST_PWAIT
  } seq_e;
endpackage
`default_nettype wire

// file: verif/cpu_stack_model.sv
// Stack memory model that answers the block's push and pop requests.
`default_nettype none
module cpu_stack_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       stk_push_q,
  input  wire logic [7:0] stk_wdata_q,
  input  wire logic       stk_pop_q,
  output logic            stk_rvalid,
  output logic [7:0]      stk_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [0:15];
  logic [3:0] sp_q;
  logic [1:0] dly_q;
  // Pops answer two cycles late, so the block must wait for the answer.
  // Outside an answer the data toggles, so a stale byte is never mistaken for a good one.
  always_ff @(posedge aclk) begin
    stk_rvalid <= 1'b0;
    stk_rdata  <= ~stk_rdata;
    if (!aresetn) begin
      sp_q      <= 4'h0;
      dly_q     <= 2'h0;
      stk_rdata <= 8'h00;
    end else begin
      if (stk_push_q) begin
        mem_q[sp_q] <= stk_wdata_q;
        sp_q        <= sp_q + 4'h1;
      end
      if (stk_pop_q) begin
        dly_q <= 2'h2;
      end else if (dly_q == 2'h1) begin
        stk_rvalid <= 1'b1;
        stk_rdata  <= mem_q[sp_q - 4'h1];
        sp_q       <= sp_q - 4'h1;
        dly_q      <= 2'h0;
      end else if (dly_q != 2'h0) begin
        dly_q <= dly_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/interrupt_priority_stacking_tb_top.sv
// Self-checking testbench for the interrupt entry block.
`default_nettype none
module interrupt_priority_stacking_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VTOP = 16'hFFFE;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, stk_rvalid, busy_q, stk_push_q, stk_pop_q;
  logic vec_load_q, restore_valid_q, i_mask_q, x_mask_q, boot_rom_sel_q, irv_drive_q;
  localparam int DONE = 0, CCRW = 1, RET = 2, TRAP = 3;
  logic mode_a_select, special_variant_flag, illegal_opcode = 0;
  logic [3:0]  pls = '0;
  logic [1:0]  strap = 2'b10;
  logic nonmaskable_request_pin_n = 1, watchdog_timer_fail = 0, internal_read = 0;
  logic [15:0] awaddr = '0, araddr = '0, mem_addr = '0, vec_addr_q;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0]  wstrb = '0;
  logic [1:0]  bresp, rresp, rs;
  logic [14:0] mask_req = '0;
  logic [7:0]  ccr_wdata = '0, stk_rdata, stk_wdata_q;
  logic [7:0]  push_exp [0:8] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hBC, 8'h9A, 8'hDE, 8'hF0, 8'h00};
  irq_pkg::cpu_ctx_s cpu_ctx = '{16'h1234, 16'h5678, 16'h9ABC, 8'hDE, 8'hF0, 8'h00};
  irq_pkg::cpu_ctx_s restore_q;
  int err_total = 0, checks_done = 0;

  always #12.5 aclk = ~aclk;

  irq_entry #(.VEC_TOP(VTOP)) i_irq_entry (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .mode_strap_pin(strap), .nonmaskable_request_pin_n(nonmaskable_request_pin_n),
    .clock_monitor_fail(1'b0), .watchdog_timer_fail(watchdog_timer_fail), .illegal_opcode(illegal_opcode),
    .mask_req(mask_req), .instr_done(pls[DONE]), .software_trap_fetch(pls[TRAP]),
    .return_from_trap_start(pls[RET]), .ccr_wr(pls[CCRW]), .ccr_wdata(ccr_wdata),
    .cpu_ctx(cpu_ctx), .stk_rvalid(stk_rvalid), .stk_rdata(stk_rdata), .mem_addr(mem_addr),
    .internal_read(internal_read), .busy_q(busy_q), .stk_push_q(stk_push_q), .stk_pop_q(stk_pop_q),
    .stk_wdata_q(stk_wdata_q), .vec_load_q(vec_load_q), .vec_addr_q(vec_addr_q),
    .restore_valid_q(restore_valid_q), .restore_q(restore_q), .i_mask_q(i_mask_q),
    .x_mask_q(x_mask_q), .boot_rom_sel_q(boot_rom_sel_q), .irv_drive_q(irv_drive_q),
    .mode_a_select(mode_a_select), .special_variant_flag(special_variant_flag));

  cpu_stack_model i_cpu_stack_model (.aclk(aclk), .aresetn(aresetn), .stk_push_q(stk_push_q),
    .stk_wdata_q(stk_wdata_q), .stk_pop_q(stk_pop_q), .stk_rvalid(stk_rvalid), .stk_rdata(stk_rdata));

  task automatic test_done;
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask

  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    if (n == 50) tmo();
    bready <= 0;
    chk(bresp, irq_pkg::RESP_OK);
  endtask

  task automatic axi_rd(input logic [15:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    if (n == 50) tmo();
    rready <= 0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic pulse(input int b);
    @(posedge aclk);
    pls[b] <= 1'b1;
    @(posedge aclk);
    pls[b] <= 1'b0;
  endtask

  task automatic wait_ev(input bit restore);
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (restore ? restore_valid_q : vec_load_q) break;
    end
    if (n == 100) tmo();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk({i_mask_q, x_mask_q}, 2'b11);
    axi_rd(irq_pkg::PRIO_OFS);
    chk(rd, 32'h0000_00C6);
    chk(mode_a_select, 1'b0);
    axi_rd(16'h2000);
    chk({rs, rd}, {irq_pkg::RESP_ERR, 32'h0000_0000});
    axi_wr(irq_pkg::PRIO_OFS, 8'hF3);
    axi_rd(irq_pkg::PRIO_OFS);
    chk({mode_a_select, rd}, {1'b1, 32'h0000_00F3});
    internal_read <= 1;
    mem_addr <= 16'hBF40;
    repeat (3) @(posedge aclk);
    chk({irv_drive_q, boot_rom_sel_q}, 2'b11);
    mem_addr <= 16'hBF3F;
    repeat (3) @(posedge aclk);
    chk(boot_rom_sel_q, 1'b0);
    pulse(CCRW);
    repeat (2) @(posedge aclk);
    chk({i_mask_q, x_mask_q}, 2'b00);
    axi_wr(irq_pkg::PRIO_OFS, 8'h95);
    axi_rd(irq_pkg::PRIO_OFS);
    chk(rd, 32'h0000_0083);
    axi_wr(irq_pkg::PRIO_OFS, 8'hF0);
    axi_rd(irq_pkg::PRIO_OFS);
    chk({irv_drive_q, rd}, {1'b0, 32'h0000_0083});
    mask_req <= 15'h2004;
    repeat (4) @(posedge aclk);
    chk(busy_q, 1'b0);
    pulse(DONE);
    wait_ev(0);
    chk(vec_addr_q, VTOP - 16'h001A);
    for (int k = 0; k < 9; k++) chk(i_cpu_stack_model.mem_q[k], push_exp[k]);
    chk({i_mask_q, x_mask_q}, 2'b10);
    mask_req <= '0;
    pulse(RET);
    wait_ev(1);
    chk(restore_q, cpu_ctx);
    repeat (2) @(posedge aclk);
    chk(i_mask_q, 1'b0);
    nonmaskable_request_pin_n <= 0;
    repeat (5) @(posedge aclk);
    pulse(DONE);
    repeat (3) @(posedge aclk);
    watchdog_timer_fail <= 1;
    illegal_opcode <= 1;
    wait_ev(0);
    chk({x_mask_q, vec_addr_q}, {1'b1, VTOP - 16'h0022});
    // The trap must win although the watchdog and illegal requests still stand.
    pulse(TRAP);
    wait_ev(0);
    chk(vec_addr_q, VTOP - 16'h001E);
    axi_rd(irq_pkg::STAT_OFS);
    chk(rd, 32'h0000_006F);
    watchdog_timer_fail <= 0;
    illegal_opcode <= 0;
    strap <= 2'b11;
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk({i_mask_q, x_mask_q, busy_q}, 3'b110);
    axi_rd(irq_pkg::PRIO_OFS);
    chk(rd, 32'h0000_0066);
    axi_wr(irq_pkg::PRIO_OFS, 8'hE6);
    axi_rd(irq_pkg::PRIO_OFS);
    chk({mode_a_select, rd}, {1'b1, 32'h0000_00E6});
    test_done();
  end
endmodule
`default_nettype wire
